// >>> rtl/acr_autostart.sv
// Purpose: Auto-start conversion sequencer with internally clocked readout.
// Assumes: Pin inputs synchronous to mclk; analog threshold given as a level.
// Notes:   Conversion time counts mclk, also when an external clock is used.
`timescale 1ns/1ps

// Contract
// R01 - Keep weak chip-select pull-up on while converting.
// R02 - At conversion end sleep and enable the 25nA chip-select sink.
// R03 - Below 1.4V chip-select threshold, wake and start output unprompted.
// R04 - Output cycle spans first to 32nd rising serial clock edge.
// R05 - Serial data changes on every falling serial clock edge.
// R06 - Generate serial clock internally and drive it on the clock pin.
// R07 - After 32nd rising edge pull chip-select high, start new conversion.
// R08 - Reselect internal clock at each crossing; clock pull-up on during discharge.
// R09 - Far side never drives serial clock low during discharge.
// R10 - Conversion lasts 66.6ms single-notch, 73ms dual-notch.
// R11 - Drive serial data low as soon as conversion completes.
// R12 - Non-watching host waits over 66.6ms or 73ms between reads.
// R13 - Front-end sampling at 76800Hz single-notch, 69900Hz dual-notch.
// R14 - External oscillator: sampling clock is that input divided by two.
// R15 - Serial data and clock held high during conversion.
// R16 - First bit is done flag low; last bit on 32nd rising edge.
// R17 - Threshold crossing is a synchronised event, once per cycle.
module acr_autostart import acr_pkg::*; #(
  parameter int CONV_SINGLE_CYCLES = CONV_SINGLE_CYC,
  parameter int CONV_DUAL_CYCLES   = CONV_DUAL_CYC
) (
  input  wire logic                 mclk,          // System clock, 20 MHz
  input  wire logic                 rst_n,         // Synchronous reset, active low
  input  wire logic                 dual_notch,    // Dual-notch variant timing
  input  wire logic                 ext_clk_sel,   // External oscillator selected
  input  wire logic                 ext_clk_in,    // External oscillator level
  input  wire logic                 cs_below_thr,  // Chip-select under threshold
  input  wire logic                 sck_i,         // Serial clock pin level
  input  wire logic [DATA_BITS-1:0] conv_data,     // Result from the filter
  output logic                      cs_pullup_en,  // Weak chip-select pull-up
  output logic                      cs_sink_en,    // Chip-select discharge sink
  output logic                      sleep,         // Low-power sleep state
  output logic                      sck_o,         // Serial clock out
  output logic                      sck_oe,        // Serial clock drive enable
  output logic                      sck_pullup_en, // Weak serial clock pull-up
  output logic                      sdo_o,         // Serial data out
  output logic                      sdo_oe,        // Serial data drive enable
  output logic                      conv_busy,     // Conversion running
  output logic                      conv_done,     // Conversion end pulse
  output logic                      int_mode,      // Internal clock mode chosen
  output logic                      samp_en        // Front-end sampling pulse
);

  acr_state_t             st_reg;
  acr_state_t             st_next;
  logic [CONV_CNT_W-1:0]  conv_cnt_reg;
  logic [CONV_CNT_W-1:0]  conv_cnt_next;
  logic [HALF_CNT_W-1:0]  half_cnt_reg;
  logic [HALF_CNT_W-1:0]  half_cnt_next;
  logic [BIT_CNT_W-1:0]   bit_cnt_reg;
  logic [BIT_CNT_W-1:0]   bit_cnt_next;
  logic [FRAME_BITS-1:0]  shreg_reg;
  logic [FRAME_BITS-1:0]  shreg_next;
  logic                   sck_reg;
  logic                   sck_next;
  logic                   sdo_reg;
  logic                   sdo_next;
  logic                   mode_reg;
  logic                   mode_next;
  logic                   done_reg;
  logic                   done_next;
  logic                   thr_s1_reg;
  logic                   thr_s2_reg;
  logic                   thr_s3_reg;
  logic                   cross_evt;
  logic                   half_end;
  logic [CONV_CNT_W-1:0]  conv_top;

  // ----------------------------------------------------------------------
  // Threshold synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      thr_s1_reg <= 1'b0;
      thr_s2_reg <= 1'b0;
      thr_s3_reg <= 1'b0;
    end else begin
      thr_s1_reg <= cs_below_thr;
      thr_s2_reg <= thr_s1_reg;
      thr_s3_reg <= thr_s2_reg;
    end
  end

  // Edge taken on the second stage; only sleep accepts it
  assign cross_evt = thr_s2_reg && !thr_s3_reg; // [R17]
  assign half_end  = (half_cnt_reg == HALF_CNT_W'(SCK_HALF_CYC - 1));
  assign conv_top  = dual_notch ? CONV_CNT_W'(CONV_DUAL_CYCLES - 1)
                                : CONV_CNT_W'(CONV_SINGLE_CYCLES - 1); // [R10]

  // ----------------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_next       = st_reg;
    conv_cnt_next = conv_cnt_reg;
    half_cnt_next = half_cnt_reg;
    bit_cnt_next  = bit_cnt_reg;
    shreg_next    = shreg_reg;
    sck_next      = sck_reg;
    sdo_next      = sdo_reg;
    mode_next     = mode_reg;
    done_next     = 1'b0;
    case (st_reg)
      ACR_CONV: begin
        sck_next = 1'b1;     // [R15]
        sdo_next = EOC_BUSY; // [R15]
        if (conv_cnt_reg == conv_top) begin
          conv_cnt_next = '0;
          done_next     = 1'b1;
          shreg_next    = {EOC_DONE, conv_data}; // [R16]
          sdo_next      = EOC_DONE;              // [R11]
          st_next       = ACR_SLEEP;             // [R02]
        end else begin
          conv_cnt_next = conv_cnt_reg + CONV_CNT_W'(1); // [R10]
        end
      end
      ACR_SLEEP: begin
        if (cross_evt) begin
          // Clock pin level at the crossing picks the timing mode
          mode_next     = sck_i; // [R08]
          half_cnt_next = '0;
          if (sck_i) begin
            sck_next = 1'b0;
            st_next  = ACR_WAKE; // [R03]
          end else begin
            // External clock mode is not served here: skip the readout
            sdo_next = EOC_BUSY;
            st_next  = ACR_CONV;
          end
        end
      end
      ACR_WAKE: begin
        // Half a serial clock period low before the first rising edge
        if (half_end) begin
          half_cnt_next = '0;
          sck_next      = 1'b1;                  // [R04]
          bit_cnt_next  = BIT_CNT_W'(1);
          st_next       = ACR_SHIFT;
        end else begin
          half_cnt_next = half_cnt_reg + HALF_CNT_W'(1);
        end
      end
      ACR_SHIFT: begin
        if (!half_end) begin
          half_cnt_next = half_cnt_reg + HALF_CNT_W'(1);
        end else if (sck_reg) begin
          half_cnt_next = '0;
          sck_next      = 1'b0;                       // [R06]
          shreg_next    = {shreg_reg[FRAME_BITS-2:0], 1'b0};
          sdo_next      = shreg_reg[FRAME_BITS-2];    // [R05]
        end else if (bit_cnt_reg == BIT_CNT_W'(FRAME_BITS - 1)) begin
          // This rising edge is the 32nd: frame ends, conversion restarts
          half_cnt_next = '0;
          bit_cnt_next  = '0;
          sck_next      = 1'b1;     // [R04]
          sdo_next      = EOC_BUSY; // [R07]
          st_next       = ACR_CONV; // [R07]
        end else begin
          half_cnt_next = '0;
          sck_next      = 1'b1;     // [R06]
          bit_cnt_next  = bit_cnt_reg + BIT_CNT_W'(1);
        end
      end
      default: begin
        st_next       = ACR_CONV;
        conv_cnt_next = '0;
        sck_next      = 1'b1;
        sdo_next      = EOC_BUSY;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg       <= ACR_CONV;
      conv_cnt_reg <= '0;
      half_cnt_reg <= '0;
      bit_cnt_reg  <= '0;
      shreg_reg    <= '0;
      sck_reg      <= 1'b1;
      sdo_reg      <= EOC_BUSY;
      mode_reg     <= 1'b1;
      done_reg     <= 1'b0;
    end else begin
      st_reg       <= st_next;
      conv_cnt_reg <= conv_cnt_next;
      half_cnt_reg <= half_cnt_next;
      bit_cnt_reg  <= bit_cnt_next;
      shreg_reg    <= shreg_next;
      sck_reg      <= sck_next;
      sdo_reg      <= sdo_next;
      mode_reg     <= mode_next;
      done_reg     <= done_next;
    end
  end

  // ----------------------------------------------------------------------
  // Pins and status
  // ----------------------------------------------------------------------
  assign cs_pullup_en  = (st_reg == ACR_CONV);  // [R01]
  assign cs_sink_en    = (st_reg == ACR_SLEEP); // [R02]
  assign sleep         = (st_reg == ACR_SLEEP); // [R02]
  // Clock released in sleep so the pull-up lets the far side be sensed
  assign sck_oe        = (st_reg != ACR_SLEEP); // [R06]
  assign sck_pullup_en = (st_reg == ACR_SLEEP); // [R08]
  assign sck_o         = sck_reg;
  assign sdo_o         = sdo_reg;
  assign sdo_oe        = 1'b1;
  assign conv_busy     = (st_reg == ACR_CONV);
  assign conv_done     = done_reg;
  assign int_mode      = mode_reg;

  acr_samp_div u_samp (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .run         (conv_busy),
    .dual_notch  (dual_notch),
    .ext_clk_sel (ext_clk_sel),
    .ext_clk_in  (ext_clk_in),
    .samp_en     (samp_en)
  );

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [CONV_CNT_W-1:0] chk_conv_cnt;
  logic [CONV_CNT_W-1:0] chk_frame_cnt;

  always_ff @(posedge mclk) begin
    if (!rst_n || st_reg != ACR_CONV) begin
      chk_conv_cnt <= '0;
    end else begin
      chk_conv_cnt <= chk_conv_cnt + CONV_CNT_W'(1);
    end
  end

  // Cycles spent in wake and shift; a lost or extra clock edge shows here
  always_ff @(posedge mclk) begin
    if (!rst_n || (st_reg != ACR_WAKE && st_reg != ACR_SHIFT)) begin
      chk_frame_cnt <= '0;
    end else begin
      chk_frame_cnt <= chk_frame_cnt + CONV_CNT_W'(1);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  cs_pullup_a: assert property (st_reg == ACR_CONV |-> cs_pullup_en && !cs_sink_en) // [R01]
    else $error("chip-select pull-up missing in conversion");
  sleep_sink_a: assert property (done_next |=> sleep && cs_sink_en && !cs_pullup_en) // [R02]
    else $error("no sleep or sink after conversion");
  wake_start_a: assert property ((sleep && cross_evt && sck_i) |=> st_reg == ACR_WAKE && !sck_o) // [R03]
    else $error("crossing did not start output");
  frame_len_a: assert property ((st_reg == ACR_SHIFT && st_next == ACR_CONV) |-> // [R04]
    chk_frame_cnt == CONV_CNT_W'((2 * FRAME_BITS - 1) * SCK_HALF_CYC - 1))
    else $error("frame is not 32 rising edges");
  sdo_fall_a: assert property ((st_reg == ACR_SHIFT && $past(st_reg) == ACR_SHIFT && $changed(sdo_o))
    |-> $fell(sck_o)) // [R05]
    else $error("data changed off a falling edge");
  sck_drive_a: assert property ((st_reg == ACR_WAKE || st_reg == ACR_SHIFT) |-> sck_oe) // [R06]
    else $error("serial clock not driven in output");
  restart_a: assert property ((st_reg == ACR_SHIFT && st_next == ACR_CONV) |=> cs_pullup_en && sdo_o && sck_o) // [R07]
    else $error("no restart after last edge");
  sck_pull_a: assert property (sleep |-> sck_pullup_en && !sck_oe) // [R08]
    else $error("clock pin not released in discharge");
  conv_len_a: assert property (done_next |-> chk_conv_cnt == conv_top) // [R10]
    else $error("conversion length wrong");
  eoc_low_a: assert property (done_next |=> !sdo_o && sdo_oe) // [R11]
    else $error("data not low at conversion end");
  conv_high_a: assert property (conv_busy && $past(conv_busy) |-> sdo_o && sck_o) // [R15]
    else $error("lines not high in conversion");
  first_bit_a: assert property (st_reg == ACR_WAKE |-> !sdo_o) // [R16]
    else $error("first bit is not the done flag");
  once_a: assert property ($rose(st_reg == ACR_WAKE) |-> $past(sleep && cross_evt && sck_i)) // [R17]
    else $error("second readout in one cycle");

  frame_c: cover property (st_reg == ACR_SHIFT ##1 conv_busy);
  ext_mode_c: cover property (sleep && cross_evt && !sck_i);
  ext_samp_c: cover property (conv_busy && ext_clk_sel && samp_en);
  dual_c: cover property (dual_notch && conv_done);

endmodule

// >>> rtl/acr_pkg.sv
// Purpose: Shared constants for the auto-start conversion readout sequencer.
// Assumes: 20 MHz system clock; all times are given in their own unit.
// Notes:   Cycle counts are derived here from the times and the clock rate.
package acr_pkg;

  // ----------------------------------------------------------------------
  // Clock
  // ----------------------------------------------------------------------
  localparam int CLK_HZ        = 20000000;
  localparam int CLK_MHZ       = 20;
  localparam int CLK_PERIOD_NS = 50;

  // ----------------------------------------------------------------------
  // Conversion time, internal oscillator
  // ----------------------------------------------------------------------
  localparam int CONV_SINGLE_US  = 66600;
  localparam int CONV_DUAL_US    = 73000;
  localparam int CONV_SINGLE_CYC = CONV_SINGLE_US * CLK_MHZ;
  localparam int CONV_DUAL_CYC   = CONV_DUAL_US * CLK_MHZ;
  localparam int CONV_CNT_W      = 21;

  // ----------------------------------------------------------------------
  // Front-end sampling clock
  // ----------------------------------------------------------------------
  localparam int SAMP_SINGLE_HZ  = 76800;
  localparam int SAMP_DUAL_HZ    = 69900;
  localparam int SAMP_SINGLE_CYC = CLK_HZ / SAMP_SINGLE_HZ;
  localparam int SAMP_DUAL_CYC   = CLK_HZ / SAMP_DUAL_HZ;
  localparam int SAMP_CNT_W      = 9;

  // ----------------------------------------------------------------------
  // Serial output frame
  // ----------------------------------------------------------------------
  localparam int SCK_HALF_NS   = 500;
  localparam int SCK_HALF_CYC  = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALF_CNT_W    = 4;
  localparam int FRAME_BITS    = 32;
  localparam int BIT_CNT_W     = 6;
  localparam int DATA_BITS     = 31;
  localparam logic EOC_DONE    = 1'h0;
  localparam logic EOC_BUSY    = 1'h1;

  typedef enum logic [3:0] {
    ACR_CONV  = 4'h1,
    ACR_SLEEP = 4'h2,
    ACR_WAKE  = 4'h4,
    ACR_SHIFT = 4'h8
  } acr_state_t;

endpackage

// >>> rtl/acr_samp_div.sv
// Purpose: Front-end sampling clock enable, internal rate or external /2.
// Assumes: ext_clk_in is synchronous to mclk and slower than mclk / 2.
// Notes:   Output is a one-cycle enable pulse, registered one cycle after a cycle with run high.
`timescale 1ns/1ps
module acr_samp_div import acr_pkg::*; (
  input  wire logic mclk,        // System clock
  input  wire logic rst_n,       // Synchronous reset, active low
  input  wire logic run,         // Conversion in progress
  input  wire logic dual_notch,  // Dual-notch variant rate
  input  wire logic ext_clk_sel, // External oscillator on select pin
  input  wire logic ext_clk_in,  // External oscillator level
  output logic      samp_en      // Sampling clock enable pulse
);

  logic [SAMP_CNT_W-1:0] cnt_reg;
  logic [SAMP_CNT_W-1:0] cnt_next;
  logic                  ext_prev_reg;
  logic                  ext_phase_reg;
  logic                  ext_phase_next;
  logic                  samp_reg;
  logic                  samp_next;
  logic [SAMP_CNT_W-1:0] top;

  // ----------------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------------
  always_comb begin
    top            = dual_notch ? SAMP_CNT_W'(SAMP_DUAL_CYC - 1) : SAMP_CNT_W'(SAMP_SINGLE_CYC - 1); // [R13]
    cnt_next       = cnt_reg;
    ext_phase_next = ext_phase_reg;
    samp_next      = 1'b0;
    if (!run) begin
      cnt_next       = '0;
      ext_phase_next = 1'b0;
    end else if (ext_clk_sel) begin
      // Every second external rising edge: period is two external periods
      if (ext_clk_in && !ext_prev_reg) begin
        ext_phase_next = !ext_phase_reg; // [R14]
        samp_next      = ext_phase_reg;  // [R14]
      end
    end else if (cnt_reg == top) begin
      cnt_next  = '0;
      samp_next = 1'b1; // [R13]
    end else begin
      cnt_next = cnt_reg + SAMP_CNT_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_reg       <= '0;
      ext_prev_reg  <= 1'b0;
      ext_phase_reg <= 1'b0;
      samp_reg      <= 1'b0;
    end else begin
      cnt_reg       <= cnt_next;
      ext_prev_reg  <= ext_clk_in;
      ext_phase_reg <= ext_phase_next;
      samp_reg      <= samp_next;
    end
  end

  assign samp_en = samp_reg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  samp_gap_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R13]
    (samp_reg && !ext_clk_sel && $past(!ext_clk_sel)) |=> (!samp_reg) [*8])
    else $error("sampling pulses too close");

endmodule

// >>> test/acr_rx_model.sv
// Purpose: Far-side receiver that captures the self-clocked result frames.
// Assumes: Frame bits are taken on rising clock line edges seen at mclk.
// Notes:   Pulls the clock line low only when the bench commands it.
`timescale 1ns/1ps
module acr_rx_model import acr_pkg::*; (
  input  wire logic                  mclk,          // System clock
  input  wire logic                  rst_n,         // Synchronous reset, active low
  input  wire logic                  sck_o,         // Device clock drive level
  input  wire logic                  sck_oe,        // Device clock drive enable
  input  wire logic                  sck_pullup_en, // Device clock pull-up
  input  wire logic                  sdo_o,         // Device data level
  input  wire logic                  sdo_oe,        // Device data drive enable
  input  wire logic                  pull_low,      // Commanded low drive on clock
  output logic                       sck_i,         // Resolved clock line
  output logic [FRAME_BITS-1:0]      frame_word,    // Last captured frame
  output logic                       frame_valid    // One-cycle frame pulse
);
  logic                 line_prev;
  logic                 sdo_last;
  logic [BIT_CNT_W-1:0] bit_cnt;
  logic [FRAME_BITS-1:0] shift_reg;
  logic                 sdo_line;

  // Drives low only on command, so the default keeps the far-side
  assign sck_i    = sck_oe ? sck_o : (pull_low ? 1'b0 : (sck_pullup_en ? 1'b1 : ~line_prev));
  // Released data line shows garbage rather than its last value
  assign sdo_line = sdo_oe ? sdo_o : ~sdo_last;

  always @(posedge mclk) begin
    frame_valid <= 1'b0;
    sdo_last    <= sdo_line;
    line_prev   <= sck_i;
    if (!rst_n || !sck_oe) begin
      bit_cnt <= '0;
    end else if (sck_i && !line_prev) begin
      // First rise carries the done flag, the 32nd the last result bit
      // Data as it stood before the rise: the device moves it on the last rise
      shift_reg <= {shift_reg[FRAME_BITS-2:0], sdo_last};
      if (bit_cnt == BIT_CNT_W'(FRAME_BITS - 1)) begin
        frame_word  <= {shift_reg[FRAME_BITS-2:0], sdo_last};
        frame_valid <= 1'b1;
        bit_cnt     <= '0;
      end else begin
        bit_cnt <= bit_cnt + 1'b1;
      end
    end
  end
endmodule

// >>> test/acr_autostart_bench.sv
// Purpose: Self-checking bench for the auto-start readout sequencer.
// Assumes: Shortened conversion counts; external oscillator at mclk / 6.
// Notes:   Frames are checked against a queue of expected words.
`timescale 1ns/1ps
module acr_autostart_bench import acr_pkg::*;;
  localparam int NS = 800;
  localparam int ND = 900;
  logic mclk = 1'b0, rst_n = 1'b0, dual_notch = 1'b0, ext_clk_sel = 1'b0, ext_clk_in = 1'b0;
  logic cs_below_thr = 1'b0, pull_low = 1'b0, sck_i, frame_valid;
  logic [DATA_BITS-1:0] conv_data = '0;
  logic [FRAME_BITS-1:0] frame_word;
  logic cs_pullup_en, cs_sink_en, sleep, sck_o, sck_oe, sck_pullup_en, sdo_o, sdo_oe;
  logic conv_busy, conv_done, int_mode, samp_en;
  logic [FRAME_BITS-1:0] exp_q[$];
  logic [15:0] lfsr = 16'hE7FD;
  int miscompares = 0, checks_done = 0, cycles = 0, conv_cnt = 0, gap = 0, ext_div = 0, frame_gap = 0;
  bit armed = 0, seen_samp = 0, prev_shift = 0;
  logic prev_sck = 1'b1, prev_sdo = 1'b1;

  acr_autostart #(.CONV_SINGLE_CYCLES(NS), .CONV_DUAL_CYCLES(ND)) DUT (
    .mclk(mclk), .rst_n(rst_n), .dual_notch(dual_notch), .ext_clk_sel(ext_clk_sel),
    .ext_clk_in(ext_clk_in), .cs_below_thr(cs_below_thr), .sck_i(sck_i), .conv_data(conv_data),
    .cs_pullup_en(cs_pullup_en), .cs_sink_en(cs_sink_en), .sleep(sleep), .sck_o(sck_o),
    .sck_oe(sck_oe), .sck_pullup_en(sck_pullup_en), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .conv_busy(conv_busy), .conv_done(conv_done), .int_mode(int_mode), .samp_en(samp_en));

  acr_rx_model RX (
    .mclk(mclk), .rst_n(rst_n), .sck_o(sck_o), .sck_oe(sck_oe), .sck_pullup_en(sck_pullup_en),
    .sdo_o(sdo_o), .sdo_oe(sdo_oe), .pull_low(pull_low), .sck_i(sck_i),
    .frame_word(frame_word), .frame_valid(frame_valid));

  always #25 mclk = ~mclk;

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    checks_done++;
    if (seen !== expv) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic test_done();
    if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Output watchers
  // ----------------------------------------------------------------------
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      test_done();
    end
  end

  always @(posedge mclk) begin
    ext_div = (ext_div == 2) ? 0 : ext_div + 1;
    if (ext_div == 0) ext_clk_in <= ~ext_clk_in;
    frame_gap++;
    if (frame_valid === 1'b1) begin
      if (exp_q.size() == 0) check(frame_word, ~frame_word);
      else check(frame_word, exp_q.pop_front());
      check(frame_gap > NS, 1'b1);
      frame_gap = 0;
    end
    if (rst_n && conv_busy === 1'b1) begin
      check({sck_o, sdo_o, sck_oe, cs_pullup_en}, 4'hF);
      conv_cnt++;
      gap++;
      if (samp_en === 1'b1) begin
        if (seen_samp) check(gap, ext_clk_sel ? 12 : (dual_notch ? 286 : 260));
        seen_samp = 1;
        gap = 0;
      end
    end else if (rst_n) begin
      if (conv_cnt != 0 && armed) check(conv_cnt, dual_notch ? ND : NS);
      if (conv_cnt != 0) armed = 1;
      conv_cnt = 0;
      gap = 0;
      seen_samp = 0;
    end
    // Data may only move where the clock falls, inside wake and shift
    if (prev_shift && sck_oe && !sleep && !conv_busy && sdo_o !== prev_sdo) check({prev_sck, sck_o}, 2'b10);
    prev_shift = sck_oe && !sleep && !conv_busy;
    prev_sck = sck_o;
    prev_sdo = sdo_o;
  end

  // ----------------------------------------------------------------------
  // One conversion and readout cycle
  // ----------------------------------------------------------------------
  task automatic run_cycle(input logic dn, input logic ext, input logic low);
    int i;
    for (i = 0; i < 3000 && sleep !== 1'b1; i++) @(posedge mclk);
    check({cs_sink_en, sck_pullup_en, cs_pullup_en, sck_oe, sdo_o, conv_done}, 6'b110001);
    if (!low) exp_q.push_back({EOC_DONE, conv_data});
    @(posedge mclk);
    check(conv_done, 1'b0);
    lfsr = lfsr_next(lfsr);
    conv_data <= DATA_BITS'({lfsr, lfsr_next(lfsr)} >> 1);
    dual_notch <= dn;
    ext_clk_sel <= ext;
    pull_low <= low;
    repeat (4) @(posedge mclk);
    check({sleep, conv_busy}, 2'b10);
    cs_below_thr <= 1'b1;
    for (i = 0; i < 1000 && conv_busy !== 1'b1; i++) @(posedge mclk);
    check({int_mode, sdo_o, sck_o}, {~low, 2'b11});
    cs_below_thr <= 1'b0;
    pull_low <= 1'b0;
    repeat (30) @(posedge mclk);
    // A crossing seen mid-conversion must not start a frame
    cs_below_thr <= 1'b1;
    repeat (5) @(posedge mclk);
    cs_below_thr <= 1'b0;
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    check({cs_pullup_en, cs_sink_en, sleep, sck_o, sck_oe, sck_pullup_en, sdo_o, sdo_oe,
           conv_busy, conv_done, int_mode, samp_en}, 12'h9BA);
    repeat (7) @(posedge mclk);
    rst_n <= 1'b1;
    run_cycle(1'b0, 1'b0, 1'b0);
    run_cycle(1'b1, 1'b0, 1'b0);
    run_cycle(1'b0, 1'b1, 1'b0);
    run_cycle(1'b0, 1'b0, 1'b1);
    run_cycle(1'b1, 1'b0, 1'b0);
    run_cycle(1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 3000 && sleep !== 1'b1; i++) @(posedge mclk);
    check(exp_q.size(), 0);
    test_done();
  end
endmodule
